// ### verilog/scsi_parity_control.sv
// Purpose: SCSI parity generation, checking and error reaction
// Assumes: Inputs from SCSI pins are raw and get synchronised here
// Notes:   Control bits arrive as plain ports from the register file
`timescale 1ns/100ps
module scsi_parity_control (
    input  wire logic       clock_i,             // 250 MHz clock
    input  wire logic       resetn_i,            // Synchronous reset, active low
    input  wire logic [7:0] scsi_control_first_i,  // First SCSI control register
    input  wire logic [7:0] scsi_control_second_i, // Second SCSI control register
    input  wire logic [7:0] scsi_irq_enable_first_i, // SCSI interrupt enables
    input  wire logic [7:0] chip_test_fourth_i,  // Chip test register four
    input  wire logic [7:0] dma_irq_enable_reg_i, // DMA interrupt enables
    input  wire logic       initiator_mode_i,    // High as initiator, low as target
    input  wire logic [7:0] tx_data_i,           // Byte to send
    input  wire logic       tx_valid_i,          // Byte to send is valid
    input  wire logic       tx_bad_parity_i,     // Send this byte with wrong parity
    input  wire logic [7:0] scsi_data_i,         // Raw SCSI data lines
    input  wire logic       scsi_data_parity_line_i, // Raw SCSI parity line
    input  wire logic       rx_strobe_i,         // Received byte strobe, same clock
    input  wire logic       transfer_done_i,     // Current transfer finished
    input  wire logic       master_data_phase_i, // Host bus master data phase
    input  wire logic       target_perr_i,       // Target signalled parity error
    input  wire logic       scsi_perr_clear_i,   // Clear SCSI parity error flag
    input  wire logic       master_perr_clear_i, // Clear master parity error flag
    output logic      [7:0] scsi_data_o,         // Data driven on the bus
    output logic            scsi_data_parity_line_o, // Parity driven on the bus
    output logic            scsi_data_oe_o,      // Data and parity drive enable
    output logic            attention_o,         // Assert SCSI attention
    output logic            halt_o,              // Halt operation request
    output logic            scsi_irq_o,          // SCSI parity interrupt request
    output logic            irq_request_o,       // Master parity interrupt request
    output logic      [7:0] scsi_irq_status_first_o, // SCSI interrupt status
    output logic      [7:0] scsi_status_first_o, // First SCSI status
    output logic      [7:0] scsi_status_second_o, // Second SCSI status
    output logic      [7:0] dma_status_reg_o,    // DMA status
    output logic      [7:0] rx_data_o            // Latched received byte
);
    // ------------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------------
    logic check_en;
    logic atn_en;
    logic even_sel;
    logic halt_dis;
    logic par_irq_en;
    logic master_chk_en;
    logic master_irq_en;

    assign check_en      = scsi_control_first_i[scsi_parity_pkg::SC1_CHECK_EN_BIT];
    assign atn_en        = scsi_control_first_i[scsi_parity_pkg::SC1_ATN_ON_ERR_BIT];
    assign even_sel      = scsi_control_second_i[scsi_parity_pkg::SC2_EVEN_SEL_BIT];
    assign halt_dis      = scsi_control_second_i[scsi_parity_pkg::SC2_HALT_DIS_BIT];
    assign par_irq_en    = scsi_irq_enable_first_i[scsi_parity_pkg::SIEN1_PAR_IRQ_BIT];
    assign master_chk_en = chip_test_fourth_i[scsi_parity_pkg::CT4_MASTER_CHK_BIT];
    assign master_irq_en = dma_irq_enable_reg_i[scsi_parity_pkg::DMA_IE_MPE_BIT];

    // ------------------------------------------------------------------
    // Pin synchronisers: three stages, change accepted when 2 and 3 agree
    // ------------------------------------------------------------------
    logic [8:0] sync1_reg;
    logic [8:0] sync2_reg;
    logic [8:0] sync3_reg;
    logic [8:0] rx_pins_reg;
    logic [8:0] sync1_next;
    logic [8:0] sync2_next;
    logic [8:0] sync3_next;
    logic [8:0] rx_pins_next;

    always_comb begin
        sync1_next   = {scsi_data_parity_line_i, scsi_data_i};
        sync2_next   = sync1_reg;
        sync3_next   = sync2_reg;
        rx_pins_next = rx_pins_reg;
        for (int i = 0; i < 9; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
                rx_pins_next[i] = sync3_reg[i];
            end
        end
        if (!resetn_i) begin
            sync1_next   = 9'h000;
            sync2_next   = 9'h000;
            sync3_next   = 9'h000;
            rx_pins_next = 9'h000;
        end
    end

    always_ff @(posedge clock_i) begin
        sync1_reg   <= sync1_next;
        sync2_reg   <= sync2_next;
        sync3_reg   <= sync3_next;
        rx_pins_reg <= rx_pins_next;
    end

    // ------------------------------------------------------------------
    // Parity units
    // ------------------------------------------------------------------
    parity_link_if link ();

    assign link.tx_data     = tx_data_i;
    assign link.tx_even     = even_sel;
    assign link.tx_corrupt  = tx_bad_parity_i;
    assign link.rx_data     = rx_pins_reg[7:0];
    assign link.rx_parity   = rx_pins_reg[8];
    assign link.rx_check_en = check_en;

    parity_gen u_gen (
        .link (link.gen_mp)
    );

    parity_chk u_chk (
        .link (link.chk_mp)
    );

    // ------------------------------------------------------------------
    // Transmit register
    // ------------------------------------------------------------------
    logic [7:0] tx_data_reg;
    logic       tx_par_reg;
    logic       tx_oe_reg;
    logic [7:0] tx_data_next;
    logic       tx_par_next;
    logic       tx_oe_next;

    always_comb begin
        tx_data_next = tx_data_reg;
        tx_par_next  = tx_par_reg;
        tx_oe_next   = tx_valid_i;
        if (tx_valid_i) begin
            tx_data_next = tx_data_i;
            tx_par_next  = link.tx_parity;
        end
        if (!resetn_i) begin
            tx_data_next = 8'h00;
            tx_par_next  = 1'b0;
            tx_oe_next   = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        tx_data_reg <= tx_data_next;
        tx_par_reg  <= tx_par_next;
        tx_oe_reg   <= tx_oe_next;
    end

    assign scsi_data_o             = tx_data_reg;
    assign scsi_data_parity_line_o = tx_par_reg;
    assign scsi_data_oe_o          = tx_oe_reg;

    // ------------------------------------------------------------------
    // Error reaction and flags
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {RUN, WAIT_END, HALTED} halt_state_t;

    halt_state_t state_reg;
    halt_state_t state_next;
    logic        scsi_err;
    logic        master_err;
    logic        scsi_flag_reg;
    logic        scsi_flag_next;
    logic        master_flag_reg;
    logic        master_flag_next;
    logic        atn_reg;
    logic        atn_next;
    logic [7:0]  rx_data_reg;
    logic [7:0]  rx_data_next;
    logic        latch_par_reg;
    logic        latch_par_next;

    assign scsi_err   = rx_strobe_i & link.rx_error;
    assign master_err = master_chk_en & master_data_phase_i & target_perr_i;

    always_comb begin
        state_next       = state_reg;
        // Set wins over a clear in the same cycle
        scsi_flag_next   = scsi_err | (scsi_flag_reg & ~scsi_perr_clear_i);
        master_flag_next = master_err | (master_flag_reg & ~master_perr_clear_i);
        atn_next         = atn_reg | (scsi_err & atn_en & initiator_mode_i);
        rx_data_next     = rx_data_reg;
        latch_par_next   = latch_par_reg;
        if (rx_strobe_i) begin
            rx_data_next   = rx_pins_reg[7:0];
            latch_par_next = rx_pins_reg[8];
        end
        if (!atn_en || !check_en) begin
            atn_next = 1'b0;
        end
        case (state_reg)
            RUN: begin
                if (scsi_err) begin
                    if (halt_dis && !initiator_mode_i) begin
                        state_next = transfer_done_i ? HALTED : WAIT_END;
                    end else begin
                        state_next = HALTED;
                    end
                end
            end
            WAIT_END: begin
                if (transfer_done_i) begin
                    state_next = HALTED;
                end else if (scsi_err && (!halt_dis || initiator_mode_i)) begin
                    state_next = HALTED;
                end
            end
            HALTED: begin
                if (scsi_perr_clear_i && !scsi_err) begin
                    state_next = RUN;
                end
            end
            default: begin
                state_next = RUN;
            end
        endcase
        if (!resetn_i) begin
            state_next       = RUN;
            scsi_flag_next   = scsi_parity_pkg::FLAG_RST;
            master_flag_next = scsi_parity_pkg::FLAG_RST;
            atn_next         = 1'b0;
            rx_data_next     = 8'h00;
            latch_par_next   = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        state_reg       <= state_next;
        scsi_flag_reg   <= scsi_flag_next;
        master_flag_reg <= master_flag_next;
        atn_reg         <= atn_next;
        rx_data_reg     <= rx_data_next;
        latch_par_reg   <= latch_par_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        scsi_irq_status_first_o = scsi_parity_pkg::STATUS_RST;
        scsi_irq_status_first_o[scsi_parity_pkg::SIST1_PAR_ERR_BIT] = scsi_flag_reg;
        scsi_status_first_o = scsi_parity_pkg::STATUS_RST;
        scsi_status_first_o[scsi_parity_pkg::SST1_LIVE_PAR_BIT] = rx_pins_reg[8];
        scsi_status_second_o = scsi_parity_pkg::STATUS_RST;
        scsi_status_second_o[scsi_parity_pkg::SST2_LATCH_PAR_BIT] = latch_par_reg;
        dma_status_reg_o = scsi_parity_pkg::STATUS_RST;
        dma_status_reg_o[scsi_parity_pkg::DMA_ST_MPE_BIT] = master_flag_reg;
    end

    assign attention_o   = atn_reg;
    assign halt_o        = (state_reg == HALTED);
    assign scsi_irq_o    = scsi_flag_reg & par_irq_en & check_en;
    assign irq_request_o = master_flag_reg & master_irq_en;
    assign rx_data_o     = rx_data_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_tx_parity;
        @(posedge clock_i) disable iff (!resetn_i)
        tx_valid_i |=> (^{scsi_data_parity_line_o, scsi_data_o})
                       == ~($past(even_sel) ^ $past(tx_bad_parity_i));
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("Bad transmit parity");

    property p_err_sets_flag;
        @(posedge clock_i) disable iff (!resetn_i)
        scsi_err |=> scsi_irq_status_first_o[0];
    endproperty
    a_err_sets_flag: assert property (p_err_sets_flag) else $error("Flag not set");

    property p_no_err_off;
        @(posedge clock_i) disable iff (!resetn_i)
        !check_en && state_reg == RUN && !scsi_flag_reg
            |=> !halt_o && !scsi_irq_status_first_o[0] && !scsi_irq_o;
    endproperty
    a_no_err_off: assert property (p_no_err_off) else $error("Error while off");

    property p_atn;
        @(posedge clock_i) disable iff (!resetn_i)
        scsi_err && atn_en && initiator_mode_i |=> attention_o;
    endproperty
    a_atn: assert property (p_atn) else $error("No attention");

    property p_halt;
        @(posedge clock_i) disable iff (!resetn_i)
        scsi_err && !halt_dis && !halt_o |=> halt_o;
    endproperty
    a_halt: assert property (p_halt) else $error("No halt");

    property p_wait_end;
        @(posedge clock_i) disable iff (!resetn_i)
        state_reg == WAIT_END && !transfer_done_i
            && !(scsi_err && (!halt_dis || initiator_mode_i)) |=> !halt_o;
    endproperty
    a_wait_end: assert property (p_wait_end) else $error("Early halt");

    property p_flag_holds;
        @(posedge clock_i) disable iff (!resetn_i)
        master_flag_reg && !master_perr_clear_i |=> dma_status_reg_o[6];
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("Flag lost");

    property p_master_irq;
        @(posedge clock_i) disable iff (!resetn_i)
        master_err && !master_irq_en ##1 !master_irq_en |-> !irq_request_o && dma_status_reg_o[6];
    endproperty
    a_master_irq: assert property (p_master_irq) else $error("Master irq wrong");
endmodule : scsi_parity_control

// ### verilog/scsi_parity_pkg.sv
// Purpose: Shared constants for the SCSI parity control block
// Assumes: 8-bit SCSI data bus plus one parity line
// Notes:   Bit positions are those of the control and status registers
package scsi_parity_pkg;
    localparam int DATA_W              = 8;
    // Control and status bit positions
    localparam int SC1_ATN_ON_ERR_BIT  = 1;
    localparam int SC1_CHECK_EN_BIT    = 3;
    localparam int SC2_EVEN_SEL_BIT    = 2;
    localparam int SC2_HALT_DIS_BIT    = 5;
    localparam int SIEN1_PAR_IRQ_BIT   = 0;
    localparam int SIST1_PAR_ERR_BIT   = 0;
    localparam int SST1_LIVE_PAR_BIT   = 0;
    localparam int SST2_LATCH_PAR_BIT  = 3;
    localparam int CT4_MASTER_CHK_BIT  = 3;
    localparam int DMA_ST_MPE_BIT      = 6;
    localparam int DMA_IE_MPE_BIT      = 6;
    // Reset values
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic       FLAG_RST    = 1'b0;
endpackage : scsi_parity_pkg

// ### verilog/parity_link_if.sv
// Purpose: Carries parity results between the parity units and the top
// Assumes: One clock domain
// Notes:   Generator and checker share this bundle
`timescale 1ns/100ps
interface parity_link_if;
    logic [7:0] tx_data;
    logic       tx_even;
    logic       tx_corrupt;
    logic       tx_parity;
    logic [7:0] rx_data;
    logic       rx_parity;
    logic       rx_check_en;
    logic       rx_error;
    modport gen_mp (input tx_data, input tx_even, input tx_corrupt, output tx_parity);
    modport chk_mp (input rx_data, input rx_parity, input rx_check_en, output rx_error);
    modport top_mp (output tx_data, output tx_even, output tx_corrupt, input tx_parity,
                    output rx_data, output rx_parity, output rx_check_en,
                    input rx_error);
endinterface : parity_link_if

// ### verilog/parity_gen.sv
// Purpose: Transmit parity generator
// Assumes: Combinational, sampled by the top
// Notes:   Odd parity unless even is selected; corrupt inverts it
`timescale 1ns/100ps
module parity_gen (
    parity_link_if.gen_mp link  // Generator side of the bundle
);
    // Odd parity makes nine bits carry an odd count of ones
    always_comb begin
        link.tx_parity = ~(^link.tx_data) ^ link.tx_even ^ link.tx_corrupt;
    end
endmodule : parity_gen

// ### verilog/parity_chk.sv
// Purpose: Receive parity checker
// Assumes: Combinational, sampled by the top
// Notes:   Always checks odd parity, whatever the transmit sense
`timescale 1ns/100ps
module parity_chk (
    parity_link_if.chk_mp link  // Checker side of the bundle
);
    always_comb begin
        link.rx_error = link.rx_check_en & ~(^{link.rx_parity, link.rx_data});
    end
endmodule : parity_chk

// ### tb/scsi_peer.sv
// Purpose: Far-side SCSI device model for the parity bench
// Assumes: Released bus lines are pulled high by the terminators
// Notes:   Sends bytes with good or bad parity, takes bytes the block drives
`timescale 1ns/100ps
module scsi_peer (
    input  wire logic       clock_i,     // Bench clock
    input  wire logic [7:0] bus_data_i,  // Resolved data lines
    input  wire logic       bus_par_i,   // Resolved parity line
    input  wire logic       dut_oe_i,    // Block drives the bus
    output logic      [7:0] data_o,      // Data driven by this device
    output logic            par_o,       // Parity driven by this device
    output logic            oe_o,        // This device drives the bus
    output logic      [7:0] seen_data_o, // Last byte taken from the bus
    output logic            seen_odd_o   // Last byte carried odd parity
);
    initial begin
        data_o = 8'h00;
        par_o = 1'b0;
        oe_o = 1'b0;
        seen_data_o = 8'h00;
        seen_odd_o = 1'b0;
    end
    // ----------------------------------------
    // Send one byte, parity odd when good
    // ----------------------------------------
    task automatic drive(input logic [7:0] d, input logic good);
        @(posedge clock_i);
        #1;
        data_o = d;
        par_o = (~^d) ^ ~good;
        oe_o = 1'b1;
    endtask : drive
    always @(posedge clock_i) begin
        if (dut_oe_i) begin
            seen_data_o <= bus_data_i;
            seen_odd_o <= ^{bus_data_i, bus_par_i};
        end
    end
endmodule : scsi_peer

// ### tb/scsi_parity_control_tb.sv
// Purpose: Self-checking bench for the SCSI parity control block
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Peer model stands on the SCSI side of the pins
`timescale 1ns/100ps
module scsi_parity_control_tb;
    logic       clock = 1'b0;
    logic       resetn = 1'b0;
    logic [7:0] ctl1 = 8'h00, ctl2 = 8'h00, sien = 8'h00, ct4 = 8'h00, dma_ie = 8'h00;
    logic       init_mode = 1'b1, tx_valid = 1'b0, tx_bad = 1'b0, rx_strobe = 1'b0;
    logic       done = 1'b0, phase = 1'b0, perr = 1'b0, sclr = 1'b0, mclr = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] d_o, sist, sst1, sst2, dma_st, rxd, bus_data, peer_data, seen_data;
    logic       p_o, oe, atn, halt, sirq, irq, bus_par, peer_par, peer_oe, seen_odd;
    int         errors = 0;
    int         comparisons = 0;
    int         cycles = 0;
    logic [7:0] bytes [4] = '{8'h00, 8'hA5, 8'h80, 8'h5B};
    logic [7:0] d;
    logic       e, b;

    always #2 clock = ~clock;
    assign bus_data = oe ? d_o : (peer_oe ? peer_data : 8'hFF);
    assign bus_par  = oe ? p_o : (peer_oe ? peer_par : 1'b1);

    scsi_parity_control uut (
        .clock_i(clock), .resetn_i(resetn), .scsi_control_first_i(ctl1),
        .scsi_control_second_i(ctl2), .scsi_irq_enable_first_i(sien),
        .chip_test_fourth_i(ct4), .dma_irq_enable_reg_i(dma_ie), .initiator_mode_i(init_mode),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_bad_parity_i(tx_bad),
        .scsi_data_i(bus_data), .scsi_data_parity_line_i(bus_par), .rx_strobe_i(rx_strobe),
        .transfer_done_i(done), .master_data_phase_i(phase), .target_perr_i(perr),
        .scsi_perr_clear_i(sclr), .master_perr_clear_i(mclr), .scsi_data_o(d_o),
        .scsi_data_parity_line_o(p_o), .scsi_data_oe_o(oe), .attention_o(atn),
        .halt_o(halt), .scsi_irq_o(sirq), .irq_request_o(irq),
        .scsi_irq_status_first_o(sist), .scsi_status_first_o(sst1),
        .scsi_status_second_o(sst2), .dma_status_reg_o(dma_st), .rx_data_o(rxd));

    scsi_peer peer (
        .clock_i(clock), .bus_data_i(bus_data), .bus_par_i(bus_par), .dut_oe_i(oe),
        .data_o(peer_data), .par_o(peer_par), .oe_o(peer_oe), .seen_data_o(seen_data),
        .seen_odd_o(seen_odd));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] bit8(input int n);
        return 8'h01 << n;
    endfunction : bit8
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic report_and_stop;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic recv(input logic [7:0] v, input logic good);
        logic par;
        par = (~^v) ^ ~good;
        peer.drive(v, good);
        tick(5);
        check(sst1, par ? bit8(scsi_parity_pkg::SST1_LIVE_PAR_BIT) : 8'h00);
        rx_strobe = 1'b1;
        tick(1);
        rx_strobe = 1'b0;
        check(rxd, v);
        check(sst2, par ? bit8(scsi_parity_pkg::SST2_LATCH_PAR_BIT) : 8'h00);
    endtask : recv
    task automatic sclear;
        sclr = 1'b1;
        tick(1);
        sclr = 1'b0;
        tick(1);
        check(sist, 8'h00);
        check({7'h00, halt}, 8'h00);
    endtask : sclear

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        tick(10);
        resetn = 1'b1;
        // ----------------------------------------
        // Transmit parity, sense and forced error
        // ----------------------------------------
        for (int i = 0; i < 8; i++) begin
            d = bytes[i % 4];
            e = i[2];
            b = i[0];
            ctl2 = e ? bit8(scsi_parity_pkg::SC2_EVEN_SEL_BIT) : 8'h00;
            tx_data = d;
            tx_bad = b;
            tx_valid = 1'b1;
            tick(1);
            tx_valid = 1'b0;
            tx_bad = 1'b0;
            check(d_o, d);
            check({7'h00, p_o}, {7'h00, (e ? ^d : ~^d) ^ b});
            check({7'h00, oe}, 8'h01);
            tick(1);
            check({7'h00, oe}, 8'h00);
            check({7'h00, seen_odd}, {7'h00, ~(e ^ b)});
            check(seen_data, d);
        end
        // ----------------------------------------
        // Receive with checking off, then on
        // ----------------------------------------
        ctl1 = bit8(scsi_parity_pkg::SC1_ATN_ON_ERR_BIT);
        sien = bit8(scsi_parity_pkg::SIEN1_PAR_IRQ_BIT);
        recv(8'h5B, 1'b0);
        check(sist, 8'h00);
        check({5'h00, atn, halt, sirq}, 8'h00);
        ctl1 = ctl1 | bit8(scsi_parity_pkg::SC1_CHECK_EN_BIT);
        ctl2 = bit8(scsi_parity_pkg::SC2_EVEN_SEL_BIT);
        recv(8'h5B, 1'b1);
        check(sist, 8'h00);
        recv(8'h5B, 1'b0);
        check(sist, bit8(scsi_parity_pkg::SIST1_PAR_ERR_BIT));
        check({5'h00, atn, halt, sirq}, 8'h07);
        sien = 8'h00;
        tick(3);
        check(sist, bit8(scsi_parity_pkg::SIST1_PAR_ERR_BIT));
        check({7'h00, sirq}, 8'h00);
        ctl1 = bit8(scsi_parity_pkg::SC1_CHECK_EN_BIT);
        tick(2);
        check({7'h00, atn}, 8'h00);
        sclear();
        // ----------------------------------------
        // Target mode, halt disabled then enabled
        // ----------------------------------------
        init_mode = 1'b0;
        ctl1 = ctl1 | bit8(scsi_parity_pkg::SC1_ATN_ON_ERR_BIT);
        ctl2 = bit8(scsi_parity_pkg::SC2_HALT_DIS_BIT);
        recv(8'h3C, 1'b0);
        check(sist, bit8(scsi_parity_pkg::SIST1_PAR_ERR_BIT));
        check({5'h00, atn, halt, sirq}, 8'h00);
        tick(2);
        check({7'h00, halt}, 8'h00);
        done = 1'b1;
        tick(1);
        done = 1'b0;
        tick(1);
        check({7'h00, halt}, 8'h01);
        sclear();
        ctl2 = 8'h00;
        sien = bit8(scsi_parity_pkg::SIEN1_PAR_IRQ_BIT);
        recv(8'h3C, 1'b0);
        check({6'h00, halt, sirq}, 8'h03);
        sclear();
        // ----------------------------------------
        // Host bus master parity errors
        // ----------------------------------------
        phase = 1'b1;
        perr = 1'b1;
        tick(2);
        check(dma_st, 8'h00);
        ct4 = bit8(scsi_parity_pkg::CT4_MASTER_CHK_BIT);
        phase = 1'b0;
        tick(2);
        check(dma_st, 8'h00);
        phase = 1'b1;
        tick(2);
        phase = 1'b0;
        perr = 1'b0;
        check(dma_st, bit8(scsi_parity_pkg::DMA_ST_MPE_BIT));
        check({7'h00, irq}, 8'h00);
        dma_ie = bit8(scsi_parity_pkg::DMA_IE_MPE_BIT);
        tick(2);
        check({7'h00, irq}, 8'h01);
        check(dma_st, bit8(scsi_parity_pkg::DMA_ST_MPE_BIT));
        mclr = 1'b1;
        tick(1);
        mclr = 1'b0;
        tick(1);
        check({dma_st[7:1], irq}, 8'h00);
        report_and_stop();
    end
endmodule : scsi_parity_control_tb
